/* File: design/pin_state_pkg.sv */
// Shared types and constants for pad state control
package pin_state_pkg;
    localparam int NUM_PINS = 8;
    localparam int STATE_W = 3;
    localparam int FUNC_W = 4;
    localparam int SYNC_STAGES = 2;
    localparam logic [STATE_W-1:0] PS_POR = 3'h0;
    localparam logic [STATE_W-1:0] PS_INT_RESET = 3'h1;
    localparam logic [STATE_W-1:0] PS_RUN = 3'h2;
    localparam logic [STATE_W-1:0] PS_TIMER = 3'h3;
    localparam logic [STATE_W-1:0] PS_DEEP = 3'h4;
    localparam logic [STATE_W-1:0] PS_RETURN = 3'h5;
    localparam logic [FUNC_W-1:0] FN_GPIO = 4'h0;
    localparam logic [FUNC_W-1:0] FN_MAIN_CLK_IN = 4'h1;
    localparam logic [FUNC_W-1:0] FN_SUB_CLK_IN = 4'h2;
    localparam logic [FUNC_W-1:0] FN_CLK_COMPANION = 4'h3;
    localparam logic [FUNC_W-1:0] FN_SUB_OSC_OUT = 4'h4;
    localparam logic [FUNC_W-1:0] FN_NMI = 4'h5;
    localparam logic [FUNC_W-1:0] FN_EXT_INT = 4'h6;
    localparam logic [FUNC_W-1:0] FN_ANALOG = 4'h7;
    localparam logic [FUNC_W-1:0] FN_TRACE = 4'h8;
    localparam logic [FUNC_W-1:0] FN_RESET_IN = 4'h9;
    localparam logic [FUNC_W-1:0] FN_MODE_IN = 4'ha;
    localparam logic [FUNC_W-1:0] FN_JTAG = 4'hb;
    localparam logic [FUNC_W-1:0] FN_RESOURCE = 4'hc;
    typedef enum logic [2:0] {
        ST_POR, ST_EXT_RESET, ST_INT_RESET, ST_RUN,
        ST_TIMER, ST_DEEP, ST_RETURN
    } pwr_state_type;
    typedef enum logic [3:0] {
        ACT_DISABLED, ACT_HIZ_IN0, ACT_HIZ_INEN, ACT_INPUT,
        ACT_PULLUP, ACT_HOLD, ACT_GPIO, ACT_GPIO_IN0,
        ACT_WAKEUP, ACT_ANALOG, ACT_TRACE
    } pin_action_type;
endpackage

/* File: design/pad_cell.sv */
// One pad: held port state, input gate and output selection
`timescale 1ns/1ps
module pad_cell
    import pin_state_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire pin_action_type action,
    input wire logic is_gpio,
    input wire logic capture,
    input wire logic periph_out,
    input wire logic periph_oe,
    input wire logic periph_active,
    input wire logic port_out,
    input wire logic port_oe,
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe,
    output logic pad_pullup,
    output logic internal_in,
    output logic analog_en,
    output logic wakeup_en
);
    logic [SYNC_STAGES-1:0] pad_sync_ff;
    logic held_out_ff;
    logic held_oe_ff;
    logic src_out;
    logic src_oe;
    logic nxt_out;
    logic nxt_oe;
    logic nxt_in_en;

    // Pad is asynchronous to sys_clk
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pad_sync_ff <= '0;
        end else begin
            pad_sync_ff <= {pad_sync_ff[0], pad_in};
        end
    end

    // Snapshot of port drive while live, frozen in standby
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            held_out_ff <= 1'b0;
            held_oe_ff <= 1'b0;
        end else if (capture) begin
            held_out_ff <= port_out;
            held_oe_ff <= port_oe;
        end
    end

    assign src_out = capture ? port_out : held_out_ff;
    assign src_oe = capture ? port_oe : held_oe_ff;

    always_comb begin
        nxt_out = 1'b0;
        nxt_oe = 1'b0;
        nxt_in_en = 1'b0;
        unique case (action)
            ACT_DISABLED, ACT_HIZ_IN0, ACT_ANALOG: begin
                nxt_in_en = 1'b0;
            end
            ACT_HIZ_INEN, ACT_INPUT, ACT_PULLUP, ACT_WAKEUP: begin
                nxt_in_en = 1'b1;
            end
            ACT_HOLD: begin
                nxt_in_en = 1'b1;
                if (!is_gpio && periph_active) begin
                    nxt_out = periph_out;
                    nxt_oe = periph_oe;
                end else begin
                    nxt_out = src_out;
                    nxt_oe = src_oe;
                end
            end
            ACT_GPIO, ACT_GPIO_IN0: begin
                nxt_in_en = (action == ACT_GPIO);
                nxt_out = src_out;
                nxt_oe = src_oe;
            end
            ACT_TRACE: begin
                nxt_out = periph_out;
                nxt_oe = periph_oe;
            end
        endcase
    end

    // driver off unless the action drives
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pad_out <= 1'b0;
            pad_oe <= 1'b0;
        end else begin
            pad_out <= nxt_out & nxt_oe;
            pad_oe <= nxt_oe;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            internal_in <= 1'b0;
            pad_pullup <= 1'b0;
            analog_en <= 1'b0;
            wakeup_en <= 1'b0;
        end else begin
            internal_in <= nxt_in_en & pad_sync_ff[SYNC_STAGES-1];
            pad_pullup <= (action == ACT_PULLUP);
            analog_en <= (action == ACT_ANALOG);
            wakeup_en <= (action == ACT_WAKEUP);
        end
    end
endmodule

/* File: design/pin_state_ctrl.sv */
// Pad state selection per power, reset and standby state
// Function
// - Low reset pin means external reset state
// - Level bit 0 holds, 1 floats
// - Unusable input reads as logic low
// - High impedance turns pad driver off
// - Hold keeps peripheral or last port value
// - Deep standby hands pads to port
// - Resets ignore disabled function selections
// - Main clock input always enabled
// - Sub clock input always enabled
// - Clock companion pin follows level bit
// - Sub oscillator output floats when stopped in standby
// - Interrupt input becomes wakeup in deep
// - External interrupt pin rules per state
// - Analog pins float with analog path
// - Trace pins keep driving in timer standby, take port in deep
// - Reset and mode pins stay inputs
`timescale 1ns/1ps
module pin_state_ctrl
    import pin_state_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic external_reset_input_n,
    input wire logic [STATE_W-1:0] power_state,
    input wire logic standby_pin_level,
    input wire logic sub_osc_stopped,
    input wire logic [NUM_PINS*FUNC_W-1:0] func_sel,
    input wire logic [NUM_PINS-1:0] periph_out,
    input wire logic [NUM_PINS-1:0] periph_oe,
    input wire logic [NUM_PINS-1:0] periph_active,
    input wire logic [NUM_PINS-1:0] port_out,
    input wire logic [NUM_PINS-1:0] port_oe,
    input wire logic [NUM_PINS-1:0] pad_in,
    output logic [NUM_PINS-1:0] pad_out,
    output logic [NUM_PINS-1:0] pad_oe,
    output logic [NUM_PINS-1:0] pad_pullup,
    output logic [NUM_PINS-1:0] internal_in,
    output logic [NUM_PINS-1:0] analog_en,
    output logic [NUM_PINS-1:0] wakeup_en
);
    logic [SYNC_STAGES-1:0] ext_rst_sync_ff;
    pwr_state_type eff_state;
    logic capture;

    // Reset pin is asynchronous to sys_clk
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ext_rst_sync_ff <= '0;
        end else begin
            ext_rst_sync_ff <= {ext_rst_sync_ff[0],
                                external_reset_input_n};
        end
    end

    always_comb begin
        eff_state = ST_POR;
        if (!ext_rst_sync_ff[SYNC_STAGES-1]) begin
            eff_state = ST_EXT_RESET;
        end else begin
            case (power_state)
                PS_POR: eff_state = ST_POR;
                PS_INT_RESET: eff_state = ST_INT_RESET;
                PS_RUN: eff_state = ST_RUN;
                PS_TIMER: eff_state = ST_TIMER;
                PS_DEEP: eff_state = ST_DEEP;
                PS_RETURN: eff_state = ST_RETURN;
                default: eff_state = ST_POR;
            endcase
        end
    end

    // Port snapshot only tracks while running
    assign capture = (eff_state == ST_RUN);

    function automatic logic in_reset(input pwr_state_type st);
        in_reset = (st == ST_POR) || (st == ST_EXT_RESET) ||
                   (st == ST_INT_RESET);
    endfunction

    function automatic pin_action_type lookup(
        input logic [FUNC_W-1:0] fn,
        input pwr_state_type st,
        input logic lvl,
        input logic stopped
    );
        logic rst;
        logic sb;
        rst = in_reset(st);
        sb = (st == ST_TIMER) || (st == ST_DEEP) || (st == ST_RETURN);
        lookup = ACT_HIZ_IN0;
        case (fn)
            FN_MAIN_CLK_IN: lookup = ACT_INPUT;
            FN_SUB_CLK_IN: lookup = ACT_INPUT;
            FN_ANALOG: lookup = ACT_ANALOG;
            FN_RESET_IN: lookup = ACT_PULLUP;
            FN_MODE_IN: lookup = ACT_INPUT;
            FN_CLK_COMPANION: begin
                if (rst) begin
                    lookup = ACT_DISABLED;
                end else if ((st == ST_TIMER || st == ST_DEEP) && lvl) begin
                    lookup = ACT_HIZ_IN0;
                end else begin
                    lookup = ACT_HOLD;
                end
            end
            FN_SUB_OSC_OUT: begin
                if (rst || (sb && stopped)) begin
                    lookup = ACT_HIZ_IN0;
                end else begin
                    lookup = ACT_HOLD;
                end
            end
            FN_NMI: begin
                if (rst) begin
                    lookup = ACT_DISABLED;
                end else if (st == ST_DEEP) begin
                    lookup = ACT_WAKEUP;
                end else if (st == ST_RETURN) begin
                    lookup = ACT_HIZ_IN0;
                end else begin
                    lookup = ACT_HOLD;
                end
            end
            FN_EXT_INT: begin
                if (rst) begin
                    lookup = ACT_DISABLED;
                end else if (st == ST_DEEP && !lvl) begin
                    lookup = ACT_GPIO_IN0;
                end else if (st == ST_DEEP || st == ST_RETURN) begin
                    lookup = ACT_HIZ_IN0;
                end else begin
                    lookup = ACT_HOLD;
                end
            end
            FN_TRACE: begin
                if (rst) begin
                    lookup = ACT_DISABLED;
                end else if (st == ST_TIMER && lvl) begin
                    lookup = ACT_TRACE;
                end else if (st == ST_DEEP) begin
                    lookup = ACT_GPIO_IN0;
                end else begin
                    lookup = ACT_HOLD;
                end
            end
            FN_JTAG: begin
                if (st == ST_POR) begin
                    lookup = ACT_HIZ_IN0;
                end else if (rst) begin
                    lookup = ACT_PULLUP;
                end else begin
                    lookup = ACT_HOLD;
                end
            end
            FN_GPIO: begin
                if (rst) begin
                    lookup = ACT_DISABLED;
                end else if (sb && lvl && st != ST_RETURN) begin
                    lookup = ACT_HIZ_IN0;
                end else if (st == ST_DEEP || st == ST_RETURN) begin
                    lookup = ACT_GPIO;
                end else begin
                    lookup = ACT_HOLD;
                end
            end
            // level bit picks hold or float in timer standby, port or float in deep standby
            default: begin
                if (st == ST_POR) begin
                    lookup = ACT_HIZ_IN0;
                end else if (rst) begin
                    lookup = ACT_HIZ_INEN;
                end else if (st == ST_DEEP && !lvl) begin
                    lookup = ACT_GPIO_IN0;
                end else if ((sb && lvl) || st == ST_RETURN) begin
                    lookup = ACT_HIZ_IN0;
                end else begin
                    lookup = ACT_HOLD;
                end
            end
        endcase
    endfunction

    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pad
        logic [FUNC_W-1:0] fn;
        pin_action_type act;
        assign fn = func_sel[i*FUNC_W +: FUNC_W];
        assign act = lookup(fn, eff_state, standby_pin_level,
                            sub_osc_stopped);
        pad_cell u_cell (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .action(act),
            .is_gpio(fn == FN_GPIO),
            .capture(capture),
            .periph_out(periph_out[i]),
            .periph_oe(periph_oe[i]),
            .periph_active(periph_active[i]),
            .port_out(port_out[i]),
            .port_oe(port_oe[i]),
            .pad_in(pad_in[i]),
            .pad_out(pad_out[i]),
            .pad_oe(pad_oe[i]),
            .pad_pullup(pad_pullup[i]),
            .internal_in(internal_in[i]),
            .analog_en(analog_en[i]),
            .wakeup_en(wakeup_en[i])
        );
    end

    // Checks watch pin 0; all pins share one lookup
    logic [FUNC_W-1:0] fn0;
    logic rst0;
    assign fn0 = func_sel[FUNC_W-1:0];
    assign rst0 = in_reset(eff_state);

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_ext_low;
        !external_reset_input_n [*3];
    endsequence

    sequence s_deep_float;
        eff_state == ST_DEEP && standby_pin_level;
    endsequence

    a_ext_reset_state: assert property (
        s_ext_low |-> eff_state == ST_EXT_RESET)
        else $error("external reset not seen after sync");

    a_float_level: assert property (
        (s_deep_float and (fn0 == FN_GPIO)) |=> !pad_oe[0])
        else $error("level bit 1 did not float the pad");

    a_input_gated: assert property (
        fn0 == FN_ANALOG |=> !internal_in[0])
        else $error("gated input not forced low");

    a_hiz_no_drive: assert property (
        rst0 && fn0 == FN_RESOURCE |=> !pad_oe[0])
        else $error("pad driven in high impedance state");

    a_hold_port: assert property (
        eff_state == ST_TIMER && !standby_pin_level &&
        fn0 == FN_GPIO && $stable(eff_state) && $stable(fn0)
        |=> pad_oe[0] == $past(pad_oe[0]) &&
            pad_out[0] == $past(pad_out[0]))
        else $error("held port value changed");

    a_deep_port: assert property (
        capture && port_oe[0] && fn0 == FN_GPIO ##1
        eff_state == ST_DEEP && !standby_pin_level &&
        fn0 == FN_GPIO |=> pad_oe[0])
        else $error("port did not take pad in deep standby");

    a_reset_ignores: assert property (
        rst0 && fn0 == FN_GPIO && periph_oe[0] && port_oe[0]
        |=> !pad_oe[0])
        else $error("selection acted during reset");

    a_main_clk_in: assert property (
        fn0 == FN_MAIN_CLK_IN ##1 fn0 == FN_MAIN_CLK_IN [*2]
        |-> internal_in[0] == $past(pad_in[0], 3))
        else $error("main clock input not passed");

    a_sub_clk_in: assert property (
        fn0 == FN_SUB_CLK_IN [*3]
        |=> internal_in[0] == $past(pad_in[0], 3))
        else $error("sub clock input not passed");

    a_companion: assert property (
        fn0 == FN_CLK_COMPANION && eff_state == ST_TIMER &&
        standby_pin_level |=> !pad_oe[0] && !internal_in[0])
        else $error("companion pin not floated");

    a_osc_stopped: assert property (
        fn0 == FN_SUB_OSC_OUT && eff_state == ST_DEEP &&
        sub_osc_stopped |=> !pad_oe[0] && !internal_in[0])
        else $error("stopped oscillator output not floated");

    a_wakeup_deep: assert property (
        fn0 == FN_NMI && eff_state == ST_DEEP
        |=> wakeup_en[0] && !pad_oe[0])
        else $error("wakeup input not enabled");

    a_ext_int_deep: assert property (
        fn0 == FN_EXT_INT && eff_state == ST_DEEP
        |=> !internal_in[0] && !wakeup_en[0])
        else $error("interrupt pin input not forced low");

    a_analog_pin: assert property (
        fn0 == FN_ANALOG |=> analog_en[0] && !pad_oe[0])
        else $error("analog pin not floated");

    a_trace_drive: assert property (
        fn0 == FN_TRACE && eff_state == ST_TIMER &&
        standby_pin_level |=> pad_oe[0] == $past(periph_oe[0]))
        else $error("trace output not driven");

    a_reset_pin_in: assert property (
        fn0 == FN_RESET_IN |=> pad_pullup[0] && !pad_oe[0])
        else $error("reset pin not a pulled-up input");

    a_jtag_pullup: assert property (
        fn0 == FN_JTAG && eff_state == ST_INT_RESET
        |=> pad_pullup[0])
        else $error("debug pin lacks pull-up in reset");
endmodule

/* File: tb/test_pin_state_power_mode_control.sv */
// Self-checking bench for pad state selection
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module test_pin_state_power_mode_control;
    import pin_state_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic external_reset_input_n = 1'b1;
    logic [STATE_W-1:0] power_state = PS_RUN;
    logic standby_pin_level = 1'b0;
    logic sub_osc_stopped = 1'b0;
    logic [NUM_PINS*FUNC_W-1:0] func_sel = '0;
    logic [NUM_PINS-1:0] periph_out = 8'hff;
    logic [NUM_PINS-1:0] periph_oe = 8'hff;
    logic [NUM_PINS-1:0] periph_active = 8'hff;
    logic [NUM_PINS-1:0] port_out = 8'hff;
    logic [NUM_PINS-1:0] port_oe = 8'hff;
    logic [NUM_PINS-1:0] pad_in = 8'hff;
    logic [NUM_PINS-1:0] pad_out;
    logic [NUM_PINS-1:0] pad_oe;
    logic [NUM_PINS-1:0] pad_pullup;
    logic [NUM_PINS-1:0] internal_in;
    logic [NUM_PINS-1:0] analog_en;
    logic [NUM_PINS-1:0] wakeup_en;
    int bad_count = 0;
    int checks = 0;

    pin_state_ctrl uut (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .external_reset_input_n(external_reset_input_n),
        .power_state(power_state),
        .standby_pin_level(standby_pin_level),
        .sub_osc_stopped(sub_osc_stopped),
        .func_sel(func_sel),
        .periph_out(periph_out),
        .periph_oe(periph_oe),
        .periph_active(periph_active),
        .port_out(port_out),
        .port_oe(port_oe),
        .pad_in(pad_in),
        .pad_out(pad_out),
        .pad_oe(pad_oe),
        .pad_pullup(pad_pullup),
        .internal_in(internal_in),
        .analog_en(analog_en),
        .wakeup_en(wakeup_en)
    );

    always #12.5 sys_clk = ~sys_clk;

    // Four edges cover the two pad sync flops plus the output flop
    task automatic settle;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic apply(input logic [STATE_W-1:0] s, input logic l,
                         input logic st);
        @(posedge sys_clk);
        power_state <= s;
        standby_pin_level <= l;
        sub_osc_stopped <= st;
        settle();
    endtask

    task automatic set_funcs(input logic [NUM_PINS*FUNC_W-1:0] f);
        @(posedge sys_clk);
        func_sel <= f;
    endtask

    // Clock and analog pins across every state and level bit
    task automatic t_always_inputs;
        set_funcs(32'h76543210);
        for (int s = 0; s < 6; s++) begin
            for (int l = 0; l < 2; l++) begin
                apply(s[STATE_W-1:0], l[0], 1'b0);
                `CHECK_EQ(internal_in[1], 1'b1);
                `CHECK_EQ(internal_in[2], 1'b1);
                `CHECK_EQ({pad_oe[7], internal_in[7], analog_en[7]}, 3'b001);
                if (s == 0) begin
                    `CHECK_EQ(pad_oe & 8'hef, 8'h00);
                end
            end
        end
        @(posedge sys_clk);
        external_reset_input_n <= 1'b0;
        apply(PS_RUN, 1'b0, 1'b0);
        `CHECK_EQ(pad_oe, 8'h00);
        `CHECK_EQ(internal_in, 8'h06);
        `CHECK_EQ(analog_en, 8'h80);
        @(posedge sys_clk);
        external_reset_input_n <= 1'b1;
        apply(PS_INT_RESET, 1'b0, 1'b0);
        `CHECK_EQ(pad_oe, 8'h00);
        `CHECK_EQ(internal_in, 8'h06);
    endtask

    // Level bit 1 floats pins even though port and peripheral drive
    task automatic t_standby_float;
        set_funcs(32'h76543210);
        apply(PS_TIMER, 1'b1, 1'b1);
        `CHECK_EQ(pad_oe & 8'h1f, 8'h00);
        `CHECK_EQ(internal_in & 8'h1f, 8'h06);
        apply(PS_DEEP, 1'b1, 1'b1);
        `CHECK_EQ(pad_oe & 8'h79, 8'h00);
        `CHECK_EQ(internal_in & 8'h59, 8'h00);
        `CHECK_EQ(wakeup_en[5], 1'b1);
    endtask

    // Held port value must survive later port register writes
    task automatic t_hold;
        set_funcs(32'h765c3210);
        apply(PS_RUN, 1'b0, 1'b0);
        `CHECK_EQ({pad_oe[0], pad_out[0]}, 2'b11);
        apply(PS_TIMER, 1'b0, 1'b0);
        @(posedge sys_clk);
        port_out <= 8'h00;
        periph_out <= 8'h00;
        settle();
        `CHECK_EQ({pad_oe[0], pad_out[0]}, 2'b11);
        `CHECK_EQ(pad_out[4], 1'b0);
        apply(PS_DEEP, 1'b0, 1'b0);
        `CHECK_EQ({pad_oe[0], pad_out[0], internal_in[0]}, 3'b111);
        `CHECK_EQ({pad_oe[4], pad_out[4], internal_in[4]}, 3'b110);
        `CHECK_EQ({pad_oe[6], pad_out[6], internal_in[6]}, 3'b110);
        `CHECK_EQ(wakeup_en[5], 1'b1);
        @(posedge sys_clk);
        port_out <= 8'hff;
        periph_out <= 8'hff;
        // Straight from run into deep standby, no timer stop between
        apply(PS_RUN, 1'b0, 1'b0);
        apply(PS_DEEP, 1'b0, 1'b0);
        `CHECK_EQ({pad_oe[0], pad_out[0]}, 2'b11);
    endtask

    // Pin 0 walks special functions 1 to 11 through every state
    task automatic t_func_sweep;
        for (int f = 1; f < 12; f++) begin
            set_funcs({28'h0000000, f[FUNC_W-1:0]});
            for (int s = 0; s < 6; s++) begin
                for (int l = 0; l < 2; l++) begin
                    apply(s[STATE_W-1:0], l[0], 1'b1);
                    if (s == 1) begin
                        `CHECK_EQ(pad_oe[0], 1'b0);
                    end
                end
            end
        end
    endtask

    // Trace, reset, mode and debug pins
    task automatic t_special;
        set_funcs(32'h000cba98);
        apply(PS_INT_RESET, 1'b0, 1'b0);
        `CHECK_EQ(pad_pullup[3:1], 3'b101);
        `CHECK_EQ(internal_in[3:1], 3'b111);
        `CHECK_EQ({pad_oe[0], internal_in[0]}, 2'b00);
        @(posedge sys_clk);
        pad_in <= 8'h00;
        settle();
        `CHECK_EQ(internal_in[2:1], 2'b00);
        @(posedge sys_clk);
        pad_in <= 8'hff;
        apply(PS_TIMER, 1'b1, 1'b0);
        `CHECK_EQ({pad_oe[0], pad_out[0]}, 2'b11);
    endtask

    task automatic complete_run;
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_always_inputs();
        t_standby_float();
        t_hold();
        t_func_sweep();
        t_special();
        complete_run();
    end

    // Whole run needs about 800 cycles
    initial begin
        #(20000 * 25);
        bad_count++;
        complete_run();
    end
endmodule
